// ==== setup_common.sv ====
// shared types and constants for the node setup decoder, plus its rate store
// assumes one 100 MHz clock; the store stands in for a small non-volatile cell
`timescale 1ns/10ps
package setup_pkg;
  typedef enum logic [1:0] {RATE_1000, RATE_800, RATE_500, RATE_250} rate_t;
  typedef enum logic [1:0] {KIND_PANEL, KIND_RACK, KIND_COMPACT, KIND_DIP} node_kind_t;

  typedef struct packed {
    logic       open_protocol;
    rate_t      rate;
    logic [7:0] address;
    logic       termination;
  } node_cfg_t;

  typedef struct packed {
    logic       protocol_switch;
    logic [1:0] bitrate_select_switches;
    logic       addr_msb_switch;
    logic [3:0] rotary_address;
    logic       termination_select_switch;
    logic [7:0] dip_switches;
  } switches_t;

  typedef struct packed {
    logic [7:0] cable_length_param;
    logic [1:0] open_bitrate_param;
    logic       protocol_mode_param;
  } ctrl_param_t;

  // apb map
  localparam int          ADDR_W           = 8;
  localparam logic [7:0]  ADDR_CTRL_PARAM  = 8'h00;
  localparam logic [7:0]  ADDR_NODE_STATUS = 8'h04;
  localparam logic [7:0]  ADDR_CTRL_RATE   = 8'h08;
  localparam int          CP_MODE_BIT      = 0;
  localparam int          CP_RATE_LSB      = 1;
  localparam int          CP_LEN_LSB       = 8;
  localparam logic [7:0]  CP_LEN_RESET     = 8'h14;
  localparam int          ST_RATE_LSB      = 0;
  localparam int          ST_PROT_BIT      = 2;
  localparam int          ST_TERM_BIT      = 3;
  localparam int          ST_CFG_BIT       = 4;
  localparam int          ST_VALID_BIT     = 5;
  localparam int          ST_DONE_BIT      = 6;
  localparam int          ST_SAVED_BIT     = 7;
  localparam int          ST_ADDR_LSB      = 8;

  // dip switch positions (switch n is bit n-1)
  localparam int DIP_RATE_LO = 0;
  localparam int DIP_RATE_HI = 1;
  localparam int DIP_SAVE    = 7;
  localparam logic [4:0] DIP_SPARE_OFF = 5'h00;

  // cable length to vendor bus rate, in metres and kHz
  localparam int LEN_STEPS = 13;
  localparam logic [7:0]  LEN_LIMIT_M [LEN_STEPS] = '{
    8'h14, 8'h1E, 8'h28, 8'h32, 8'h3C, 8'h46, 8'h50,
    8'h5A, 8'h64, 8'h6E, 8'h78, 8'h82, 8'hFF};
  localparam logic [15:0] LEN_KHZ [LEN_STEPS] = '{
    16'h03E8, 16'h0378, 16'h0320, 16'h02D7, 16'h029A, 16'h0267, 16'h023B,
    16'h0215, 16'h01F4, 16'h01E0, 16'h01AE, 16'h0190, 16'h00FA};
  localparam logic [15:0] KHZ_1000 = 16'h03E8;
  localparam logic [15:0] KHZ_800  = 16'h0320;
  localparam logic [15:0] KHZ_500  = 16'h01F4;
  localparam logic [15:0] KHZ_250  = 16'h00FA;

  // leds: bit0 stop, bit1 run, bit2 tx, bit3 rx
  localparam logic [3:0] LED_OFF  = 4'h0;
  localparam logic [3:0] LED_TX   = 4'h4;
  localparam logic [3:0] LED_1000 = 4'hF;
  localparam logic [3:0] LED_800  = 4'h1;
  localparam logic [3:0] LED_500  = 4'h2;
  localparam logic [3:0] LED_250  = 4'h3;

  // timing
  localparam int CLK_KHZ       = 100000;
  localparam int BLINK_HALF_MS = 250;
  localparam int SETTLE_CYCLES = 3;

  function automatic logic [15:0] rate_khz(input rate_t r);
    unique case (r)
      RATE_1000: rate_khz = KHZ_1000;
      RATE_800:  rate_khz = KHZ_800;
      RATE_500:  rate_khz = KHZ_500;
      RATE_250:  rate_khz = KHZ_250;
    endcase
  endfunction
endpackage

module rate_store (
  // clock and cold init
  input  wire logic            pclk,
  input  wire logic            nvm_init_n,
  // write side
  input  wire logic            write_en,
  input  wire setup_pkg::rate_t write_rate,
  // stored value
  output setup_pkg::rate_t     stored_rate,
  output logic                 stored_valid
);
  // cleared only by the cold init, so a module reset keeps the saved rate
  always_ff @(posedge pclk or negedge nvm_init_n) begin
    if (!nvm_init_n) begin
      stored_rate  <= setup_pkg::RATE_1000;
      stored_valid <= 1'b0;
    end else if (write_en) begin
      stored_rate  <= write_rate;
      stored_valid <= 1'b1;
    end
  end
endmodule

// ==== can_node_setup_decoder.sv ====
// can node setup decoder: samples the switches once after reset and holds the
// decoded protocol, rate, address and termination; runs the dip module's rate
// configuration mode and the controller's parameter-driven rate choice.
// assumes switches are asynchronous pins and software is an apb master.
//
// Decided for this implementation: register access over APB and the placing of the registers.
`timescale 1ns/10ps
module can_node_setup_decoder #(
  parameter setup_pkg::node_kind_t NODE_KIND = setup_pkg::KIND_PANEL,
  parameter int BLINK_HALF_CYCLES = setup_pkg::BLINK_HALF_MS * setup_pkg::CLK_KHZ
) (
  // clock and resets
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic                          nvm_init_n,
  // apb slave
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [setup_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [31:0]                   pwdata,
  output logic [31:0]                        prdata,
  output logic                               pready,
  output logic                               pslverr,
  // switch pins
  input  wire setup_pkg::switches_t          switch_pins,
  // decoded setup
  output setup_pkg::node_cfg_t               node_cfg,
  output logic                               setup_done,
  output logic                               config_mode,
  output logic [3:0]                         led,
  output logic [15:0]                        ctrl_rate_khz
);
  localparam int CNT_W = $clog2(BLINK_HALF_CYCLES + 1);
  localparam int SET_W = $clog2(setup_pkg::SETTLE_CYCLES + 1);

  typedef enum {ST_SETTLE, ST_RUN, ST_CONFIG, ST_SAVED} state_t;

  state_t                 state;
  setup_pkg::switches_t   sync_a;
  setup_pkg::switches_t   sw;
  logic                   save_prev;
  logic [SET_W-1:0]       settle_cnt;
  logic                   capture;
  logic [CNT_W-1:0]       blink_cnt;
  logic                   blink_phase;
  setup_pkg::ctrl_param_t ctrl_param;
  setup_pkg::rate_t       stored_rate;
  logic                   stored_valid;
  setup_pkg::rate_t       dip_sel_rate;
  setup_pkg::node_cfg_t   next_cfg;
  logic                   save_req;
  logic [3:0]             next_led;
  logic [15:0]            next_ctrl_khz;
  logic [31:0]            next_rdata;
  logic                   addr_hit;

  // two-stage synchroniser; only sw is read by logic
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_a <= '0;
      sw     <= '0;
    end else begin
      sync_a <= switch_pins;
      sw     <= sync_a;
    end
  end

  function automatic setup_pkg::rate_t panel_rate(input logic s2, input logic s3,
                                                  input logic compact);
    unique case ({s2, s3})
      2'b11: panel_rate = setup_pkg::RATE_1000;
      2'b01: panel_rate = setup_pkg::RATE_800;
      2'b10: panel_rate = setup_pkg::RATE_500;
      2'b00: panel_rate = compact ? setup_pkg::RATE_500 : setup_pkg::RATE_250;
    endcase
  endfunction

  function automatic setup_pkg::rate_t dip_rate(input logic d1, input logic d2);
    unique case ({d2, d1})
      2'b00: dip_rate = setup_pkg::RATE_1000;
      2'b01: dip_rate = setup_pkg::RATE_800;
      2'b10: dip_rate = setup_pkg::RATE_500;
      2'b11: dip_rate = setup_pkg::RATE_250;
    endcase
  endfunction

  function automatic logic [3:0] saved_leds(input setup_pkg::rate_t r);
    unique case (r)
      setup_pkg::RATE_1000: saved_leds = setup_pkg::LED_1000;
      setup_pkg::RATE_800:  saved_leds = setup_pkg::LED_800;
      setup_pkg::RATE_500:  saved_leds = setup_pkg::LED_500;
      setup_pkg::RATE_250:  saved_leds = setup_pkg::LED_250;
    endcase
  endfunction

  // settle counter lets the synchroniser fill before the single capture
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settle_cnt <= '0;
    end else if (state == ST_SETTLE && !capture) begin
      settle_cnt <= settle_cnt + SET_W'(1);
    end
  end
  assign capture = (state == ST_SETTLE) &&
                   (settle_cnt == SET_W'(setup_pkg::SETTLE_CYCLES));

  assign dip_sel_rate = dip_rate(sw.dip_switches[setup_pkg::DIP_RATE_LO],
                                 sw.dip_switches[setup_pkg::DIP_RATE_HI]);
  // dips three to seven must be off for a save to count
  assign save_req = (state == ST_CONFIG) && sw.dip_switches[setup_pkg::DIP_SAVE] &&
                    !save_prev &&
                    (sw.dip_switches[setup_pkg::DIP_SAVE-1:setup_pkg::DIP_RATE_HI+1]
                     == setup_pkg::DIP_SPARE_OFF);

  always_comb begin
    next_cfg             = '0;
    next_cfg.termination = sw.termination_select_switch;
    if (NODE_KIND == setup_pkg::KIND_DIP) begin
      next_cfg.open_protocol = 1'b1;
      next_cfg.rate          = stored_valid ? stored_rate : setup_pkg::RATE_1000;
      next_cfg.address       = sw.dip_switches;
    end else begin
      next_cfg.open_protocol = (NODE_KIND == setup_pkg::KIND_PANEL) ?
                               sw.protocol_switch : 1'b1;
      next_cfg.rate          = panel_rate(sw.bitrate_select_switches[0],
                                          sw.bitrate_select_switches[1],
                                          NODE_KIND == setup_pkg::KIND_COMPACT);
      next_cfg.address       = {3'h0, sw.addr_msb_switch, sw.rotary_address};
    end
  end

  // taken once per reset, so later switch moves are ignored until the next one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      node_cfg <= '0;
    end else if (capture) begin
      node_cfg <= next_cfg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_SETTLE;
    end else begin
      unique case (state)
        ST_SETTLE: if (capture) begin
          if (NODE_KIND == setup_pkg::KIND_DIP && sw.dip_switches == 8'h00) begin
            state <= ST_CONFIG;
          end else begin
            state <= ST_RUN;
          end
        end
        ST_CONFIG: if (save_req) begin
          state <= ST_SAVED;
        end
        // leaving saved needs a presetn reset; no switch setting, dip eight included, is checked for it
        ST_SAVED: state <= ST_SAVED;
        ST_RUN:   state <= ST_RUN;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      save_prev <= 1'b0;
    end else begin
      save_prev <= sw.dip_switches[setup_pkg::DIP_SAVE];
    end
  end

  rate_store u_store (
    .pclk         (pclk),
    .nvm_init_n   (nvm_init_n),
    .write_en     (save_req),
    .write_rate   (dip_sel_rate),
    .stored_rate  (stored_rate),
    .stored_valid (stored_valid)
  );

  // blink divider only runs in configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blink_cnt   <= '0;
      blink_phase <= 1'b0;
    end else if (state != ST_CONFIG) begin
      blink_cnt   <= '0;
      blink_phase <= 1'b0;
    end else if (blink_cnt == CNT_W'(BLINK_HALF_CYCLES - 1)) begin
      blink_cnt   <= '0;
      blink_phase <= !blink_phase;
    end else begin
      blink_cnt   <= blink_cnt + CNT_W'(1);
    end
  end

  always_comb begin
    next_led = setup_pkg::LED_OFF;
    if (state == ST_CONFIG && blink_phase) begin
      next_led = stored_valid ? sw.dip_switches[3:0] : setup_pkg::LED_TX;
    end else if (state == ST_SAVED) begin
      next_led = saved_leds(stored_rate);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      led <= setup_pkg::LED_OFF;
    end else begin
      led <= next_led;
    end
  end

  assign setup_done  = (state != ST_SETTLE);
  assign config_mode = (state == ST_CONFIG) || (state == ST_SAVED);

  // controller side: protocol and rate from software parameters
  always_comb begin
    next_ctrl_khz = setup_pkg::LEN_KHZ[setup_pkg::LEN_STEPS-1];
    if (ctrl_param.protocol_mode_param) begin
      next_ctrl_khz = setup_pkg::rate_khz(setup_pkg::rate_t'(ctrl_param.open_bitrate_param));
    end else begin
      for (int i = setup_pkg::LEN_STEPS - 2; i >= 0; i--) begin
        if (ctrl_param.cable_length_param <= setup_pkg::LEN_LIMIT_M[i]) begin
          next_ctrl_khz = setup_pkg::LEN_KHZ[i];
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_rate_khz <= setup_pkg::KHZ_1000;
    end else begin
      ctrl_rate_khz <= next_ctrl_khz;
    end
  end

  // apb: zero wait states, read data registered in the setup cycle
  assign addr_hit = (paddr == setup_pkg::ADDR_CTRL_PARAM) ||
                    (paddr == setup_pkg::ADDR_NODE_STATUS) ||
                    (paddr == setup_pkg::ADDR_CTRL_RATE);
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !addr_hit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_param                    <= '0;
      ctrl_param.cable_length_param <= setup_pkg::CP_LEN_RESET;
    end else if (psel && penable && pwrite && paddr == setup_pkg::ADDR_CTRL_PARAM) begin
      ctrl_param.protocol_mode_param <= pwdata[setup_pkg::CP_MODE_BIT];
      ctrl_param.open_bitrate_param  <= pwdata[setup_pkg::CP_RATE_LSB +: 2];
      ctrl_param.cable_length_param  <= pwdata[setup_pkg::CP_LEN_LSB +: 8];
    end
  end

  always_comb begin
    next_rdata = '0;
    unique case (paddr)
      setup_pkg::ADDR_CTRL_PARAM: begin
        next_rdata[setup_pkg::CP_MODE_BIT]     = ctrl_param.protocol_mode_param;
        next_rdata[setup_pkg::CP_RATE_LSB +: 2] = ctrl_param.open_bitrate_param;
        next_rdata[setup_pkg::CP_LEN_LSB +: 8]  = ctrl_param.cable_length_param;
      end
      setup_pkg::ADDR_NODE_STATUS: begin
        next_rdata[setup_pkg::ST_RATE_LSB +: 2] = node_cfg.rate;
        next_rdata[setup_pkg::ST_PROT_BIT]      = node_cfg.open_protocol;
        next_rdata[setup_pkg::ST_TERM_BIT]      = node_cfg.termination;
        next_rdata[setup_pkg::ST_CFG_BIT]       = config_mode;
        next_rdata[setup_pkg::ST_VALID_BIT]     = stored_valid;
        next_rdata[setup_pkg::ST_DONE_BIT]      = setup_done;
        next_rdata[setup_pkg::ST_SAVED_BIT]     = (state == ST_SAVED);
        next_rdata[setup_pkg::ST_ADDR_LSB +: 8] = node_cfg.address;
      end
      setup_pkg::ADDR_CTRL_RATE: next_rdata[15:0] = ctrl_rate_khz;
      default: next_rdata = '0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (psel && !penable) begin
      prdata <= next_rdata;
    end
  end

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  hold_cfg_a: assert property (setup_done |=> $stable(node_cfg))
    else $error("node setup changed after capture");
  late_switch_a: assert property (setup_done && $changed(sw) |=> $stable(node_cfg))
    else $error("switch change applied without reset");
  protocol_pick_a: assert property (capture && NODE_KIND == setup_pkg::KIND_PANEL
    |=> node_cfg.open_protocol == $past(sw.protocol_switch))
    else $error("protocol switch not followed");
  panel_rate_a: assert property (capture && NODE_KIND != setup_pkg::KIND_DIP
    && sw.bitrate_select_switches == 2'b11 |=> node_cfg.rate == setup_pkg::RATE_1000)
    else $error("both rate switches on must give 1000 kHz");
  no_slow_rate_a: assert property (NODE_KIND == setup_pkg::KIND_COMPACT
    |-> node_cfg.rate != setup_pkg::RATE_250)
    else $error("compact node reached 250 kHz");
  config_entry_a: assert property (capture && NODE_KIND == setup_pkg::KIND_DIP
    && sw.dip_switches == 8'h00 |=> state == ST_CONFIG ##1 config_mode)
    else $error("all dips off did not enter configuration");
  dip_address_a: assert property (capture && NODE_KIND == setup_pkg::KIND_DIP
    && sw.dip_switches != 8'h00 |=> state == ST_RUN
    && node_cfg.address == $past(sw.dip_switches))
    else $error("dip pattern not taken as address");
  blink_mirror_a: assert property (state == ST_CONFIG && blink_phase && stored_valid
    && $stable(sw) |=> led == $past(sw.dip_switches[3:0]))
    else $error("config leds do not mirror dips");
  tx_only_a: assert property (state == ST_CONFIG && !stored_valid
    |=> led == setup_pkg::LED_OFF || led == setup_pkg::LED_TX)
    else $error("missing rate must blink tx alone");
  save_rate_a: assert property (save_req |=> state == ST_SAVED && stored_valid
    && stored_rate == $past(dip_sel_rate) ##1 led == saved_leds(stored_rate))
    else $error("save did not store rate or light leds");
  cable_rate_a: assert property (!ctrl_param.protocol_mode_param
    && ctrl_param.cable_length_param > setup_pkg::LEN_LIMIT_M[setup_pkg::LEN_STEPS-2]
    |=> ctrl_rate_khz == setup_pkg::KHZ_250)
    else $error("long cable must give 250 kHz");
  mode_param_a: assert property (ctrl_param.protocol_mode_param |=> ctrl_rate_khz
    == setup_pkg::rate_khz(setup_pkg::rate_t'($past(ctrl_param.open_bitrate_param))))
    else $error("open mode rate not from parameter");

  enter_config_c: cover property (state == ST_SETTLE ##1 state == ST_CONFIG);
  saved_c:        cover property (state == ST_CONFIG ##1 state == ST_SAVED);
  run_addr_c:     cover property (capture ##1 state == ST_RUN);
  open_ctrl_c:    cover property (ctrl_param.protocol_mode_param ##1 ctrl_rate_khz != 16'h0000);
endmodule

// ==== peer_node_model.sv ====
// far-end model: one more open-protocol node sharing the bus with the panel
// assumes the node under test presents its decoded setup; only pclk exists
`timescale 1ns/10ps
module peer_node_model #(
  parameter setup_pkg::rate_t PEER_RATE = setup_pkg::RATE_1000
) (
  // clock and reset
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // node under test
  input  wire setup_pkg::node_cfg_t node_cfg,
  input  wire logic                 setup_done,
  // verdict
  output logic                      rate_agrees
);
  // a peer only talks once both ends use the open protocol at one rate
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rate_agrees <= 1'b0;
    end else begin
      rate_agrees <= setup_done && node_cfg.open_protocol && (node_cfg.rate == PEER_RATE);
    end
  end
endmodule

// ==== can_node_setup_decoder_tb.sv ====
// self-checking bench: panel, dip-configured and compact nodes on one apb bus
// assumes zero-wait apb answers and switch capture a few edges after reset
`timescale 1ns/10ps
module can_node_setup_decoder_tb;
  logic                 pclk;
  logic                 presetn;
  logic                 nvm_init_n;
  logic                 psel;
  logic                 penable;
  logic                 pwrite;
  logic [7:0]           paddr;
  logic [31:0]          pwdata;
  logic [31:0]          prdata;
  logic                 pready;
  logic                 pslverr;
  setup_pkg::switches_t psw;
  setup_pkg::switches_t dsw;
  setup_pkg::node_cfg_t node_cfg;
  setup_pkg::node_cfg_t dnode;
  setup_pkg::node_cfg_t cnode;
  logic                 setup_done;
  logic                 dsetup_done;
  logic                 dconfig_mode;
  logic [3:0]           dled;
  logic [15:0]          ctrl_rate_khz;
  logic                 rate_agrees;
  int                   failures;
  int                   tests_run;

  can_node_setup_decoder #(.NODE_KIND(setup_pkg::KIND_PANEL), .BLINK_HALF_CYCLES(4)) dut (
    .pclk(pclk), .presetn(presetn), .nvm_init_n(nvm_init_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .switch_pins(psw), .node_cfg(node_cfg), .setup_done(setup_done),
    .config_mode(), .led(), .ctrl_rate_khz(ctrl_rate_khz));
  can_node_setup_decoder #(.NODE_KIND(setup_pkg::KIND_DIP), .BLINK_HALF_CYCLES(4)) dip_dut (
    .pclk(pclk), .presetn(presetn), .nvm_init_n(nvm_init_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(), .pready(), .pslverr(),
    .switch_pins(dsw), .node_cfg(dnode), .setup_done(dsetup_done),
    .config_mode(dconfig_mode), .led(dled), .ctrl_rate_khz());
  can_node_setup_decoder #(.NODE_KIND(setup_pkg::KIND_COMPACT), .BLINK_HALF_CYCLES(4)) compact_dut (
    .pclk(pclk), .presetn(presetn), .nvm_init_n(nvm_init_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(), .pready(), .pslverr(),
    .switch_pins(psw), .node_cfg(cnode), .setup_done(), .config_mode(), .led(),
    .ctrl_rate_khz());
  peer_node_model #(.PEER_RATE(setup_pkg::RATE_1000)) peer (
    .pclk(pclk), .presetn(presetn), .node_cfg(node_cfg), .setup_done(setup_done),
    .rate_agrees(rate_agrees));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic give_up();
    failures++;
    results();
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    int n;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) give_up();
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // switches must already be set; they stay put until capture
  task automatic restart(input int cycles);
    int n;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (cycles) @(posedge pclk);
    presetn    <= 1'b1;
    nvm_init_n <= 1'b1;
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while ((setup_done & dsetup_done) !== 1'b1 && n < 20);
    if ((setup_done & dsetup_done) !== 1'b1) give_up();
  endtask

  // two blink periods at half period 4: or and and of every led sample
  task automatic blink(output logic [3:0] lor, output logic [3:0] land);
    lor  = 4'h0;
    land = 4'hF;
    repeat (16) begin
      @(negedge pclk);
      lor  = lor | dled;
      land = land & dled;
    end
  endtask

  initial begin
    logic [31:0]          rd;
    logic                 er;
    logic [3:0]           lor;
    logic [3:0]           land;
    setup_pkg::node_cfg_t exp;
    setup_pkg::rate_t     rate_exp [4];
    logic [7:0]           len [6];
    logic [15:0]          khz [6];
    rate_exp = '{setup_pkg::RATE_250, setup_pkg::RATE_500, setup_pkg::RATE_800,
                 setup_pkg::RATE_1000};
    len = '{8'h14, 8'h19, 8'h32, 8'h64, 8'h82, 8'h83};
    khz = '{16'h03E8, 16'h0378, 16'h02D7, 16'h01F4, 16'h0190, 16'h00FA};
    presetn    = 1'b0;
    nvm_init_n = 1'b0;
    psel       = 1'b0;
    penable    = 1'b0;
    pwrite     = 1'b0;
    paddr      = 8'h00;
    pwdata     = 32'h0;
    psw        = '0;
    dsw        = '0;
    failures   = 0;
    tests_run  = 0;
    restart(16);
    check(32'(dconfig_mode), 32'h1);
    blink(lor, land);
    check(32'({lor, land}), 32'({setup_pkg::LED_TX, setup_pkg::LED_OFF}));
    @(posedge pclk);
    dsw.dip_switches <= 8'h84;
    repeat (8) @(posedge pclk);
    blink(lor, land);
    check(32'({lor, land}), 32'({setup_pkg::LED_TX, setup_pkg::LED_OFF}));
    // the save acts on a rising dip eight, so lower it before the real save
    @(posedge pclk);
    dsw.dip_switches <= 8'h01;
    repeat (4) @(posedge pclk);
    dsw.dip_switches <= 8'h81;
    repeat (8) @(posedge pclk);
    blink(lor, land);
    check(32'({lor, land}), 32'({setup_pkg::LED_800, setup_pkg::LED_800}));
    check(32'(dconfig_mode), 32'h1);
    $display("dip configuration test done");
    @(posedge pclk);
    dsw.dip_switches <= 8'h05;
    for (int i = 0; i < 4; i++) begin
      @(posedge pclk);
      psw <= '{protocol_switch: i[0], bitrate_select_switches: 2'(i), addr_msb_switch: i[1],
               rotary_address: 4'(i + 3), termination_select_switch: i[0], dip_switches: 8'h00};
      restart(4);
      exp = '{open_protocol: i[0], rate: rate_exp[i], address: {3'h0, i[1], 4'(i + 3)},
              termination: i[0]};
      check(32'(node_cfg), 32'(exp));
      check(32'(cnode.rate), 32'((i == 0) ? setup_pkg::RATE_500 : rate_exp[i]));
      check(32'(dnode), 32'({1'b1, setup_pkg::RATE_800, 8'h05, 1'b0}));
      @(posedge pclk);
      psw <= ~psw;
      repeat (8) @(posedge pclk);
      check(32'(node_cfg), 32'(exp));
      check(32'(rate_agrees), 32'(i == 3));
    end
    $display("switch decode test done");
    apb(1'b0, setup_pkg::ADDR_CTRL_PARAM, 32'h0, rd, er);
    check(rd, 32'h00001400);
    apb(1'b0, setup_pkg::ADDR_NODE_STATUS, 32'h0, rd, er);
    check(rd, 32'h0000164C);
    for (int k = 0; k < 6; k++) begin
      apb(1'b1, setup_pkg::ADDR_CTRL_PARAM, {16'h0, len[k], 8'h00}, rd, er);
      apb(1'b0, setup_pkg::ADDR_CTRL_RATE, 32'h0, rd, er);
      check(rd, {16'h0, khz[k]});
      check({16'h0, ctrl_rate_khz}, {16'h0, khz[k]});
    end
    apb(1'b1, setup_pkg::ADDR_CTRL_PARAM, 32'h00008203, rd, er);
    apb(1'b1, setup_pkg::ADDR_CTRL_RATE, 32'h0, rd, er);
    apb(1'b0, setup_pkg::ADDR_CTRL_RATE, 32'h0, rd, er);
    check(rd, 32'h00000320);
    apb(1'b0, 8'h0C, 32'h0, rd, er);
    check({er, rd[30:0]}, 32'h80000000);
    $display("controller register test done");
    @(posedge pclk);
    dsw.dip_switches <= 8'h00;
    restart(4);
    @(posedge pclk);
    dsw.dip_switches <= 8'h02;
    repeat (4) @(posedge pclk);
    blink(lor, land);
    check(32'({lor, land}), 32'({4'h2, setup_pkg::LED_OFF}));
    $display("led mirror test done");
    results();
  end

  initial begin
    repeat (20000) @(posedge pclk);
    give_up();
  end
endmodule
